// File: iocs_map.svh
// Constants for the IO controller start-up sequencer
`ifndef IOCS_MAP_SVH
`define IOCS_MAP_SVH

// ****************************************
// Blink timing
// ****************************************
`define IOCS_CLK_HZ 10000000
`define IOCS_BLINK_HALF_MS 250
`define IOCS_BLINK_HALF_CYC ((`IOCS_CLK_HZ / 1000) * `IOCS_BLINK_HALF_MS)

// ****************************************
// Cyclic exchange timing
// ****************************************
`define IOCS_CYCLE_US 1000
`define IOCS_CYCLE_CYC ((`IOCS_CLK_HZ / 1000000) * `IOCS_CYCLE_US)

// ****************************************
// Field layout of an output telegram word
// ****************************************
`define IOCS_OUT_VALID_BIT 8
`define IOCS_OUT_DATA_MSB 7
`define IOCS_OUT_ZERO 8'h00

`endif

// File: iocs_pkg.sv
// Types for the IO controller start-up sequencer
package iocs_pkg;
    typedef enum logic [2:0] {
        IOCS_ST_OFF = 3'b000,
        IOCS_ST_IDLE = 3'b001,
        IOCS_ST_ADDR = 3'b010,
        IOCS_ST_RELATE = 3'b011,
        IOCS_ST_WAIT = 3'b100,
        IOCS_ST_READY = 3'b101
    } iocs_state_t;
endpackage

// File: iocs_buf2.sv
// Two-entry skid buffer with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module iocs_buf2 #(
    parameter int WIDTH = 9
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem_q [0:1];
    logic wr_ptr_q;
    logic rd_ptr_q;
    logic [1:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (cnt_q != 2'd2);
    assign out_valid = (cnt_q != 2'd0);
    assign out_data = mem_q[rd_ptr_q];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            cnt_q <= 2'd0;
        end else if (clk_en) begin
            if (push) begin
                mem_q[wr_ptr_q] <= in_data;
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule
`default_nettype wire

// File: iocs_sequencer.sv
// IO controller start-up and run-state sequencer
// Function
// - Factory state: controller stays disabled after power-on, all LEDs dark.
// - Project data received: leave idle, enter system start-up.
// - Start-up assigns each configured device its address by discovery.
// - Start-up sets up communication and application relation per device.
// - Bus-fault lit steadily when devices configured but cable missing.
// - Valid project data starts start-up, shown by flashing bus-fault.
// - Bus-fault blinks, once start-up has begun, while any configured device is not yet in cyclic exchange.
// - Configuration handed over automatically on new config only, not at power-on.
// - CPU stopped: inputs still copied cyclically to CPU input area.
// - CPU running: outputs fetched and sent, inputs copied cyclically.
`timescale 1ns/1ns
`default_nettype none
`include "iocs_map.svh"
module iocs_sequencer
    import iocs_pkg::*;
#(
    parameter int NDEV = 4,
    parameter int DEV_W = 2,
    parameter int BLINK_HALF = `IOCS_BLINK_HALF_CYC,
    parameter int CYCLE_CYC = `IOCS_CYCLE_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic factory_state,
    input wire logic project_load,
    input wire logic project_valid,
    input wire logic [NDEV-1:0] dev_configured,
    input wire logic cable_present,
    input wire logic [NDEV-1:0] dev_cyclic,
    input wire logic cpu_run,
    input wire logic [7:0] cpu_out_data,
    output logic cfg_req,
    output logic [DEV_W-1:0] cfg_dev,
    output logic cfg_addr_cmd,
    output logic cfg_relation_cmd,
    input wire logic cfg_done,
    output logic ctrl_enable,
    output logic bus_fault_indicator,
    output logic system_ready,
    output logic out_fetch,
    output logic tel_valid,
    output logic [8:0] tel_data,
    input wire logic tel_ready,
    input wire logic in_valid,
    input wire logic [7:0] in_data,
    output logic in_ready,
    output logic cpu_in_we,
    output logic [7:0] cpu_in_data
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [NDEV-1:0] cfgd_s1_q, cfgd_q, cyc_s1_q, cyc_q;
    logic cable_s1_q, cable_q, fact_s1_q, fact_q, run_s1_q, run_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cfgd_s1_q <= '0;
            cfgd_q <= '0;
            cyc_s1_q <= '0;
            cyc_q <= '0;
            cable_s1_q <= 1'b0;
            cable_q <= 1'b0;
            fact_s1_q <= 1'b1;
            fact_q <= 1'b1;
            run_s1_q <= 1'b0;
            run_q <= 1'b0;
        end else if (clk_en) begin
            cfgd_s1_q <= dev_configured;
            cfgd_q <= cfgd_s1_q;
            cyc_s1_q <= dev_cyclic;
            cyc_q <= cyc_s1_q;
            cable_s1_q <= cable_present;
            cable_q <= cable_s1_q;
            fact_s1_q <= factory_state;
            fact_q <= fact_s1_q;
            run_s1_q <= cpu_run;
            run_q <= run_s1_q;
        end
    end

    // ****************************************
    // Start-up state machine
    // ****************************************
    iocs_state_t st_q, st_d;
    logic [DEV_W-1:0] dev_q, dev_d;
    logic cfg_req_q, cfg_req_d;
    logic cfg_issued_q, cfg_issued_d;

    wire new_project = project_load && project_valid;
    wire any_cfgd = |cfgd_q;
    wire all_cyclic = ((cyc_q & cfgd_q) == cfgd_q);
    wire last_dev = (dev_q == DEV_W'(NDEV - 1));
    wire dev_used = cfgd_q[dev_q];
    wire cable_fault = any_cfgd && !cable_q;
    wire blink_cond = (st_q == IOCS_ST_ADDR) || (st_q == IOCS_ST_RELATE)
        || (st_q == IOCS_ST_WAIT && !all_cyclic);

    always_comb begin
        st_d = st_q;
        dev_d = dev_q;
        cfg_req_d = 1'b0;
        cfg_issued_d = cfg_issued_q;
        case (st_q)
            IOCS_ST_OFF: begin
                // A valid project starts up at once, even from delivery state
                if (new_project) begin
                    st_d = IOCS_ST_ADDR;
                    dev_d = '0;
                    cfg_issued_d = 1'b0;
                end else if (!fact_q) begin
                    st_d = IOCS_ST_IDLE;
                end
            end
            IOCS_ST_IDLE: begin
                if (new_project) begin
                    st_d = IOCS_ST_ADDR;
                    dev_d = '0;
                    cfg_issued_d = 1'b0;
                end
            end
            IOCS_ST_ADDR, IOCS_ST_RELATE: begin
                if (!dev_used) begin
                    cfg_issued_d = 1'b0;
                    if (last_dev) begin
                        dev_d = '0;
                        st_d = (st_q == IOCS_ST_ADDR) ? IOCS_ST_RELATE
                            : IOCS_ST_WAIT;
                    end else begin
                        dev_d = dev_q + 1'b1;
                    end
                end else if (!cfg_issued_q) begin
                    cfg_req_d = 1'b1;
                    cfg_issued_d = 1'b1;
                end else if (cfg_done) begin
                    cfg_issued_d = 1'b0;
                    if (last_dev) begin
                        dev_d = '0;
                        st_d = (st_q == IOCS_ST_ADDR) ? IOCS_ST_RELATE
                            : IOCS_ST_WAIT;
                    end else begin
                        dev_d = dev_q + 1'b1;
                    end
                end
            end
            IOCS_ST_WAIT: begin
                if (all_cyclic) begin
                    st_d = IOCS_ST_READY;
                end
            end
            IOCS_ST_READY: begin
                if (!all_cyclic) begin
                    st_d = IOCS_ST_WAIT;
                end
            end
            default: begin
                st_d = IOCS_ST_OFF;
            end
        endcase
        // New configuration restarts start-up from any active state
        if (new_project && st_q != IOCS_ST_OFF && st_q != IOCS_ST_IDLE) begin
            st_d = IOCS_ST_ADDR;
            dev_d = '0;
            cfg_issued_d = 1'b0;
            cfg_req_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_q <= IOCS_ST_OFF;
            dev_q <= '0;
            cfg_req_q <= 1'b0;
            cfg_issued_q <= 1'b0;
        end else if (clk_en) begin
            st_q <= st_d;
            dev_q <= dev_d;
            cfg_req_q <= cfg_req_d;
            cfg_issued_q <= cfg_issued_d;
        end
    end

    // ****************************************
    // Bus-fault indicator
    // ****************************************
    // Blink uses a free counter so the phase never stalls on state changes
    logic [$clog2(BLINK_HALF+1)-1:0] blink_cnt_q;
    logic blink_ph_q, bf_q, ready_q, en_q, cfg_addr_q, cfg_rel_q;
    logic [DEV_W-1:0] cfg_dev_q;
    wire blink_wrap = (blink_cnt_q == $bits(blink_cnt_q)'(BLINK_HALF - 1));
    wire ctrl_on = (st_q != IOCS_ST_OFF);
    wire bf_d = !ctrl_on ? 1'b0
        : cable_fault ? 1'b1
        : blink_cond ? blink_ph_q
        : 1'b0;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            blink_cnt_q <= '0;
            blink_ph_q <= 1'b0;
            bf_q <= 1'b0;
            ready_q <= 1'b0;
            en_q <= 1'b0;
            cfg_dev_q <= '0;
            cfg_addr_q <= 1'b0;
            cfg_rel_q <= 1'b0;
        end else if (clk_en) begin
            blink_cnt_q <= blink_wrap ? '0 : blink_cnt_q + 1'b1;
            blink_ph_q <= blink_wrap ? ~blink_ph_q : blink_ph_q;
            bf_q <= bf_d;
            ready_q <= (st_q == IOCS_ST_READY);
            en_q <= ctrl_on;
            cfg_dev_q <= dev_d;
            cfg_addr_q <= cfg_req_d && (st_q == IOCS_ST_ADDR);
            cfg_rel_q <= cfg_req_d && (st_q == IOCS_ST_RELATE);
        end
    end

    // ****************************************
    // Cyclic data exchange
    // ****************************************
    logic [$clog2(CYCLE_CYC+1)-1:0] cyc_cnt_q;
    logic fetch_q;
    wire cyc_wrap = (cyc_cnt_q == $bits(cyc_cnt_q)'(CYCLE_CYC - 1));
    wire exch_on = (st_q == IOCS_ST_WAIT) || (st_q == IOCS_ST_READY);
    wire tick = exch_on && cyc_wrap;
    wire buf_in_ready;
    // Stop forces invalid flag and zero bytes; telegram still sent
    wire [8:0] tel_word = run_q ? {1'b1, cpu_out_data}
        : {1'b0, `IOCS_OUT_ZERO};

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cyc_cnt_q <= '0;
            fetch_q <= 1'b0;
        end else if (clk_en) begin
            cyc_cnt_q <= (cyc_wrap || !exch_on) ? '0 : cyc_cnt_q + 1'b1;
            fetch_q <= tick && run_q && buf_in_ready;
        end
    end

    // A full buffer skips one cycle rather than stalling the sequencer
    iocs_buf2 #(.WIDTH(9)) u_out_buf (
        .core_clk(core_clk),
        .rst(rst),
        .clk_en(clk_en),
        .in_valid(tick),
        .in_ready(buf_in_ready),
        .in_data(tel_word),
        .out_valid(tel_valid),
        .out_ready(tel_ready),
        .out_data(tel_data)
    );

    // Inputs copied in both run and stop
    logic in_ready_q, in_we_q;
    logic [7:0] in_data_q;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            in_ready_q <= 1'b0;
            in_we_q <= 1'b0;
            in_data_q <= 8'h00;
        end else if (clk_en) begin
            in_ready_q <= exch_on;
            in_we_q <= in_valid && in_ready_q;
            if (in_valid && in_ready_q) begin
                in_data_q <= in_data;
            end
        end
    end

    assign cfg_req = cfg_req_q;
    assign cfg_dev = cfg_dev_q;
    assign cfg_addr_cmd = cfg_addr_q;
    assign cfg_relation_cmd = cfg_rel_q;
    assign ctrl_enable = en_q;
    assign bus_fault_indicator = bf_q;
    assign system_ready = ready_q;
    assign out_fetch = fetch_q;
    assign in_ready = in_ready_q;
    assign cpu_in_we = in_we_q;
    assign cpu_in_data = in_data_q;
endmodule
`default_nettype wire

// File: iocs_sequencer_properties.sv
// Concurrent checks on the ports of the start-up sequencer
`timescale 1ns/1ns
`default_nettype none
module iocs_sequencer_properties #(
    parameter int NDEV = 4
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [NDEV-1:0] dev_configured,
    input wire logic cable_present,
    input wire logic cfg_req,
    input wire logic cfg_addr_cmd,
    input wire logic cfg_relation_cmd,
    input wire logic ctrl_enable,
    input wire logic bus_fault_indicator,
    input wire logic system_ready,
    input wire logic out_fetch,
    input wire logic tel_valid,
    input wire logic [8:0] tel_data,
    input wire logic tel_ready,
    input wire logic in_valid,
    input wire logic [7:0] in_data,
    input wire logic in_ready,
    input wire logic cpu_in_we,
    input wire logic [7:0] cpu_in_data
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Four cycles cover the two-stage pin sync plus the indicator register
    sequence cable_gone;
        (ctrl_enable && clk_en && |dev_configured && !cable_present)[*4];
    endsequence
    sequence all_up;
        (system_ready && clk_en && cable_present)[*4];
    endsequence
    off_dark_a: assert property (!ctrl_enable && !$past(ctrl_enable) |->
        !bus_fault_indicator && !cfg_req && !tel_valid)
        else $error("activity while controller disabled");
    cable_steady_a: assert property (cable_gone |-> bus_fault_indicator)
        else $error("indicator not steady with cable missing");
    ready_dark_a: assert property (all_up |-> !bus_fault_indicator)
        else $error("indicator lit with all devices exchanging");
    job_kind_a: assert property (cfg_req |-> cfg_addr_cmd != cfg_relation_cmd)
        else $error("job request without exactly one job kind");
    job_pulse_a: assert property (cfg_req |=> !cfg_req [*2])
        else $error("job request not a single pulse");
    tel_hold_a: assert property (tel_valid && !tel_ready |=>
        tel_valid && $stable(tel_data))
        else $error("telegram changed while stalled");
    stop_zero_a: assert property (tel_valid && !tel_data[8] |->
        tel_data[7:0] == 8'h00)
        else $error("invalid telegram carries data");
    fetch_sent_a: assert property (out_fetch |-> tel_valid)
        else $error("fetch without telegram offered");
    in_copy_a: assert property (in_valid && in_ready && clk_en |=>
        cpu_in_we && cpu_in_data == $past(in_data))
        else $error("accepted input word not copied");
    we_cause_a: assert property (cpu_in_we |-> $past(in_valid) && $past(in_ready))
        else $error("input copy without accepted word");
endmodule
bind iocs_sequencer iocs_sequencer_properties #(.NDEV(NDEV)) i_props (
    .core_clk, .rst, .clk_en, .dev_configured, .cable_present, .cfg_req,
    .cfg_addr_cmd, .cfg_relation_cmd, .ctrl_enable, .bus_fault_indicator,
    .system_ready, .out_fetch, .tel_valid, .tel_data, .tel_ready, .in_valid,
    .in_data, .in_ready, .cpu_in_we, .cpu_in_data);
`default_nettype wire

// File: iocs_dev_model.sv
// Far-side model: remote devices answering jobs and streaming inputs
`timescale 1ns/1ns
`default_nettype none
module iocs_dev_model #(
    parameter int NDEV = 4,
    parameter int DEV_W = 2
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic stall,
    input wire logic feed,
    input wire logic cfg_req,
    input wire logic [DEV_W-1:0] cfg_dev,
    input wire logic cfg_relation_cmd,
    input wire logic in_ready,
    output logic cfg_done,
    output logic [NDEV-1:0] dev_cyclic,
    output logic in_valid,
    output logic [7:0] in_data,
    output logic tel_ready
);
    // ****************************************
    // Behaviour
    // ****************************************
    logic [4:0] wait_q;
    logic rel_q;
    logic [DEV_W-1:0] dev_q;
    logic [7:0] cnt_q;
    assign tel_ready = !stall;
    always_ff @(posedge core_clk) begin
        cfg_done <= 1'b0;
        if (rst) begin
            wait_q <= 5'h00;
            dev_cyclic <= '0;
            in_valid <= 1'b0;
            in_data <= 8'h00;
            cnt_q <= 8'h00;
        end else begin
            if (cfg_req) begin
                wait_q <= slow ? 5'h0C : 5'h01;
                rel_q <= cfg_relation_cmd;
                dev_q <= cfg_dev;
            end else if (wait_q != 5'h00) begin
                wait_q <= wait_q - 5'h01;
                cfg_done <= wait_q == 5'h01;
                if (wait_q == 5'h01 && rel_q) begin
                    dev_cyclic[dev_q] <= 1'b1;
                end
            end
            // Word held until taken; idle data toggles so stale use shows
            if (!in_valid || in_ready) begin
                in_valid <= feed;
                in_data <= feed ? cnt_q : ~in_data;
                cnt_q <= cnt_q + {7'h00, feed};
            end
        end
    end
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking testbench for the start-up sequencer
`timescale 1ns/1ns
`default_nettype none
module tb;
    // ****************************************
    // Bench
    // ****************************************
    localparam int BH = 4;
    int n_mismatch = 0;
    int n_tests = 0;
    int n_fetch = 0;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic factory_state = 1'b1;
    logic project_load = 1'b0;
    logic project_valid = 1'b0;
    logic [3:0] dev_configured = 4'hB;
    logic cable_present = 1'b1;
    logic cpu_run = 1'b0;
    logic [7:0] cpu_out_data = 8'h00;
    logic slow = 1'b0;
    logic stall = 1'b0;
    logic feed = 1'b0;
    logic cfg_req, cfg_addr_cmd, cfg_relation_cmd, cfg_done, ctrl_enable;
    logic bus_fault_indicator, system_ready, out_fetch, tel_valid, tel_ready;
    logic in_valid, in_ready, cpu_in_we;
    logic [1:0] cfg_dev;
    logic [3:0] dev_cyclic;
    logic [7:0] in_data, cpu_in_data;
    logic [8:0] tel_data;
    logic [8:0] tq[$];
    logic [7:0] iq[$];
    logic [2:0] cq[$];
    iocs_sequencer #(.BLINK_HALF(BH), .CYCLE_CYC(8)) i_iocs_sequencer (
        .core_clk, .rst, .clk_en(1'b1), .factory_state, .project_load,
        .project_valid, .dev_configured, .cable_present, .dev_cyclic, .cpu_run,
        .cpu_out_data, .cfg_req, .cfg_dev, .cfg_addr_cmd, .cfg_relation_cmd,
        .cfg_done, .ctrl_enable, .bus_fault_indicator, .system_ready,
        .out_fetch, .tel_valid, .tel_data, .tel_ready, .in_valid, .in_data,
        .in_ready, .cpu_in_we, .cpu_in_data);
    iocs_dev_model i_iocs_dev_model (.core_clk, .rst, .slow, .stall, .feed,
        .cfg_req, .cfg_dev, .cfg_relation_cmd, .in_ready, .cfg_done,
        .dev_cyclic, .in_valid, .in_data, .tel_ready);
    always #50 core_clk = ~core_clk;
    // Logged at the edge, as the design itself samples them
    always @(posedge core_clk) begin
        if (tel_valid && tel_ready) tq.push_back(tel_data);
        if (cpu_in_we) iq.push_back(cpu_in_data);
        if (cfg_req) cq.push_back({cfg_relation_cmd, cfg_dev});
        if (out_fetch) n_fetch++;
    end
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic close_out();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Missing cable while still off must stay dark
    task automatic t_factory();
        cable_present = 1'b0;
        cyc(20);
        check(ctrl_enable, 1'b0);
        check(bus_fault_indicator, 1'b0);
        cable_present = 1'b1;
    endtask
    task automatic t_startup();
        int t;
        logic b;
        logic [2:0] exp[6] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h7};
        slow = 1'b1;
        project_load = 1'b1;
        project_valid = 1'b1;
        cyc(1);
        project_load = 1'b0;
        cyc(12);
        b = bus_fault_indicator;
        for (t = 0; t < 20 && bus_fault_indicator === b; t++) cyc(1);
        b = bus_fault_indicator;
        for (t = 0; t < 20 && bus_fault_indicator === b; t++) cyc(1);
        check(9'(t), 9'(BH));
        for (t = 0; t < 600 && system_ready !== 1'b1; t++) cyc(1);
        check(system_ready, 1'b1);
        cyc(2);
        check(bus_fault_indicator, 1'b0);
        check(9'(cq.size()), 9'h006);
        foreach (exp[i]) check(cq[i], exp[i]);
    endtask
    task automatic t_stop();
        tq.delete();
        iq.delete();
        feed = 1'b1;
        cyc(40);
        feed = 1'b0;
        check(tq.size() >= 4, 1'b1);
        foreach (tq[i]) check(tq[i], 9'h000);
        check(iq.size() > 4, 1'b1);
        foreach (iq[i]) check(iq[i], 8'(i));
    endtask
    // Receiver stalls five ticks; the two buffered telegrams must survive
    task automatic t_run();
        int k;
        cpu_run = 1'b1;
        cpu_out_data = 8'hA5;
        cyc(6);
        tq.delete();
        k = iq.size();
        stall = 1'b1;
        feed = 1'b1;
        cyc(40);
        check(tel_valid, 1'b1);
        check(9'(tq.size()), 9'h000);
        stall = 1'b0;
        cyc(20);
        feed = 1'b0;
        check(tq.size() >= 3, 1'b1);
        foreach (tq[i]) check(tq[i], 9'h1A5);
        check(n_fetch > 0, 1'b1);
        check(iq.size() > k + 4, 1'b1);
    endtask
    task automatic t_cable();
        int t;
        cable_present = 1'b0;
        cyc(5);
        repeat (8) begin
            check(bus_fault_indicator, 1'b1);
            cyc(1);
        end
        cable_present = 1'b1;
        cyc(5);
        check(bus_fault_indicator, 1'b0);
        // New configuration while ready must run start-up again
        project_load = 1'b1;
        cyc(1);
        project_load = 1'b0;
        cyc(3);
        check(system_ready, 1'b0);
        for (t = 0; t < 600 && system_ready !== 1'b1; t++) cyc(1);
        check(system_ready, 1'b1);
    endtask
    initial begin
        cyc(16);
        rst = 1'b0;
        t_factory();
        t_startup();
        t_stop();
        t_run();
        t_cable();
        close_out();
    end
    initial begin
        #2000000;
        n_mismatch++;
        close_out();
    end
endmodule
`default_nettype wire
